//--- uep4_defines.svh
// Purpose: register offsets, field positions and reset values of the endpoint 4 transmit slice
// Assumes: 16-bit register port with byte addresses as printed
// Notes:   definitions only
// Contract
// [RQ1] cpu data write pushes low byte
// [RQ2] host in transfers drain fifo bytes
// [RQ3] count register reports entries zero to sixty-four
// [RQ4] valid bit lets next host read proceed
// [RQ5] host read completion clears valid bit
// [RQ6] valid gates reads only when enabled
// [RQ7] flush bit empties fifo, reads zero
// [RQ8] write to full fifo sets overflow
// [RQ9] overflow cleared only by writing one
// [RQ10] full bit shows fifo at capacity
// [RQ11] empty bit shows no entries, set at reset
// [RQ12] packet size in eight-byte units, default sixty-four
// [RQ13] packet size reported in host descriptor
// [RQ14] read-only revision byte
// [RQ15] per endpoint ack nak stall flags, write-one clear
// [RQ16] suspend request bit, write one enters suspend; the code enters suspend only while the request bit is already set
// [RQ17] lowest bit flags mailbox valid
`ifndef UEP4_DEFINES_SVH
`define UEP4_DEFINES_SVH

`define UEP4_OFF_DATA    16'h4028
`define UEP4_OFF_COUNT   16'h402A
`define UEP4_OFF_FLAGS   16'h402C
`define UEP4_OFF_PKT     16'h402E
`define UEP4_OFF_REV     16'h4030
`define UEP4_OFF_HS      16'h4032
`define UEP4_OFF_IRQ_ST  16'h4040
`define UEP4_OFF_IRQ_EN  16'h4042

`define UEP4_FLG_EMPTY   0
`define UEP4_FLG_FULL    1
`define UEP4_FLG_OVF     3
`define UEP4_FLG_FLUSH   4
`define UEP4_FLG_VALID   5
`define UEP4_HS_SUSPEND  7

`define UEP4_IRQ_OVF     0
`define UEP4_IRQ_DONE    1
`define UEP4_IRQ_DRAIN   2

`define UEP4_RST_PKT     8'h08
`define UEP4_RST_IRQ_EN  3'h0
`define UEP4_FIFO_DEPTH  64
// arbitrary value, not a real part's revision
`define UEP4_REV_DEFAULT 8'h5A

`endif

//--- uep4_pkg.sv
// Purpose: shared types of the endpoint 4 transmit slice
// Assumes: offsets and fields live in uep4_defines.svh
// Notes:   handshake struct order matches the status register bit order
package uep4_pkg;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } uep4_bus_s;

    typedef struct packed {
        logic suspend_req;
        logic ep4_stall;
        logic ep4_nak;
        logic ep4_ack;
        logic ep3_stall;
        logic ep3_nak;
        logic ep3_ack;
        logic ep2_valid;
    } uep4_hs_s;

endpackage

//--- uep4_tx.sv
// Purpose: endpoint 4 transmit fifo, its status, packet size, revision and handshake status
// Assumes: link-side strobes come from protocol logic on the same clock
// Notes:   read data stands one cycle after the read strobe; one level interrupt
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "uep4_defines.svh"

module uep4_tx
#(
    parameter int unsigned DEPTH    = `UEP4_FIFO_DEPTH,
    parameter logic [7:0]  REVISION = `UEP4_REV_DEFAULT
)
(
    input  wire logic                clock,         // system clock
    input  wire logic                sys_rst,       // async reset, active high
    input  wire uep4_pkg::uep4_bus_s bus,           // cpu register request
    output logic [15:0]              rdata,         // read data, cycle after rd
    input  wire logic                host_pop,      // host takes one byte
    input  wire logic                host_done,     // host read completed
    input  wire logic                valid_gate_en, // valid bit gating enabled
    input  wire uep4_pkg::uep4_hs_s  hs_evt,        // handshake event pulses
    output logic [7:0]               host_data,     // byte for the host
    output logic                     host_avail,    // a byte may be taken
    output logic [7:0]               ep4_max_pkt,   // descriptor packet size
    output logic                     suspend_go,    // enter suspend, pulse
    output logic                     irq            // interrupt level
);
    import uep4_pkg::*;

    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned CW = $clog2(DEPTH + 1);

    ////////////////////////////////////////////////////////////////////////
    // state

    logic [7:0]    mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          valid_q;
    logic          valid_d;
    logic          ovf_q;
    logic          ovf_d;
    logic [7:0]    hs_q;
    logic [7:0]    hs_d;
    logic [7:0]    pkt_q;
    logic [2:0]    ip_q;
    logic [2:0]    ip_d;
    logic [2:0]    ie_q;
    logic [2:0]    ie_d;
    logic [7:0]    host_data_q;
    logic          host_avail_q;
    logic          suspend_q;
    logic          irq_q;
    logic [15:0]   rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // address decode

    wire sel_data  = bus.addr == `UEP4_OFF_DATA;
    wire sel_count = bus.addr == `UEP4_OFF_COUNT;
    wire sel_flags = bus.addr == `UEP4_OFF_FLAGS;
    wire sel_pkt   = bus.addr == `UEP4_OFF_PKT;
    wire sel_rev   = bus.addr == `UEP4_OFF_REV;
    wire sel_hs    = bus.addr == `UEP4_OFF_HS;
    wire sel_ist   = bus.addr == `UEP4_OFF_IRQ_ST;
    wire sel_ien   = bus.addr == `UEP4_OFF_IRQ_EN;

    wire wr_data  = bus.wr && sel_data;
    wire wr_flags = bus.wr && sel_flags;
    wire wr_pkt   = bus.wr && sel_pkt;
    wire wr_hs    = bus.wr && sel_hs;
    wire wr_ist   = bus.wr && sel_ist;
    wire wr_ien   = bus.wr && sel_ien;

    ////////////////////////////////////////////////////////////////////////
    // fifo control

    // [RQ10] full at capacity
    wire full  = cnt_q == CW'(DEPTH);
    // [RQ11] empty at zero
    wire empty = cnt_q == '0;

    // [RQ7] flush on write of one
    wire flush = wr_flags && bus.wdata[`UEP4_FLG_FLUSH];

    // [RQ1] push low byte unless full
    wire push = wr_data && !full && !flush;

    // [RQ8] write while full is an overflow
    wire ovf_evt = wr_data && full;

    // [RQ6] gate only when enabled
    wire allow = !valid_gate_en || valid_q;

    // [RQ2] host drains a byte
    wire pop = host_pop && !empty && allow && !flush;

    wire [7:0] pop_byte = mem[rd_ptr_q];

    // [RQ3] entry count
    assign cnt_d = flush ? '0 : CW'(cnt_q + CW'(push) - CW'(pop));

    // [RQ5] host completion clears valid; a cpu write in that cycle wins
    assign valid_d = wr_flags ? bus.wdata[`UEP4_FLG_VALID]
                   : (host_done ? 1'b0 : valid_q);

    // [RQ9] sticky, write-one clear, set wins
    assign ovf_d = ovf_evt || (ovf_q && !(wr_flags && bus.wdata[`UEP4_FLG_OVF]));

    ////////////////////////////////////////////////////////////////////////
    // handshake status

    wire [7:0] hs_clr = wr_hs ? bus.wdata[7:0] : 8'h00;

    // [RQ15] sticky handshake flags, set wins over clear
    // [RQ17] bit 0 mailbox valid
    assign hs_d = 8'(hs_evt) | (hs_q & ~hs_clr);

    // [RQ16] suspend only when a request stands
    wire suspend_d = wr_hs && bus.wdata[`UEP4_HS_SUSPEND] && hs_q[`UEP4_HS_SUSPEND];

    ////////////////////////////////////////////////////////////////////////
    // interrupts

    wire [2:0] irq_evt;
    assign irq_evt[`UEP4_IRQ_OVF]   = ovf_evt;
    assign irq_evt[`UEP4_IRQ_DONE]  = host_done;
    assign irq_evt[`UEP4_IRQ_DRAIN] = pop && !push && (cnt_q == CW'(1));

    wire [2:0] ip_clr = wr_ist ? bus.wdata[2:0] : 3'h0;
    assign ip_d = irq_evt | (ip_q & ~ip_clr);
    assign ie_d = wr_ien ? bus.wdata[2:0] : ie_q;

    ////////////////////////////////////////////////////////////////////////
    // read mux

    wire [7:0] flags_rd = {2'b00, valid_q, 1'b0, ovf_q, 1'b0, full, empty};

    // [RQ14] revision is a constant
    wire [15:0] rd_word = sel_count ? 16'(cnt_q)
                        : sel_flags ? {8'h00, flags_rd}
                        : sel_pkt   ? {8'h00, pkt_q}
                        : sel_rev   ? {8'h00, REVISION}
                        : sel_hs    ? {8'h00, hs_q}
                        : sel_ist   ? {13'h0000, ip_q}
                        : sel_ien   ? {13'h0000, ie_q}
                        : 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // registers

    // storage has no reset; only entries below the count are ever read
    always_ff @(posedge clock)
    begin
        if (push)
            mem[wr_ptr_q] <= bus.wdata[7:0];
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
        end
        else
        begin
            wr_ptr_q <= flush ? '0 : AW'(wr_ptr_q + AW'(push));
            rd_ptr_q <= flush ? '0 : AW'(rd_ptr_q + AW'(pop));
            cnt_q    <= cnt_d;
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            valid_q <= 1'b0;
            ovf_q   <= 1'b0;
            hs_q    <= 8'h00;
            ip_q    <= 3'h0;
            ie_q    <= `UEP4_RST_IRQ_EN;
        end
        else
        begin
            valid_q <= valid_d;
            ovf_q   <= ovf_d;
            hs_q    <= hs_d;
            ip_q    <= ip_d;
            ie_q    <= ie_d;
        end
    end

    // [RQ12] packet size register, eight-byte units
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            pkt_q <= `UEP4_RST_PKT;
        else if (wr_pkt)
            pkt_q <= bus.wdata[7:0];
    end

    // [RQ2] byte held for the host after each pop
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            host_data_q <= 8'h00;
        else if (pop)
            host_data_q <= pop_byte;
    end

    // [RQ4] availability follows next count and valid
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            host_avail_q <= 1'b0;
        else
            host_avail_q <= (cnt_d != '0) && (!valid_gate_en || valid_d);
    end

    // next-state terms keep irq aligned with the status it reflects
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            suspend_q <= 1'b0;
            irq_q     <= 1'b0;
            rdata_q   <= 16'h0000;
        end
        else
        begin
            suspend_q <= suspend_d;
            irq_q     <= |(ip_d & ie_d);
            rdata_q   <= bus.rd ? rd_word : 16'h0000;
        end
    end

    assign rdata       = rdata_q;
    assign host_data   = host_data_q;
    assign host_avail  = host_avail_q;
    // [RQ13] descriptor packet size
    assign ep4_max_pkt = pkt_q;
    assign suspend_go  = suspend_q;
    assign irq         = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    push_count_a: assert property (push && !pop |=> cnt_q == $past(cnt_q) + 1'b1) // [RQ1]
        else $error("push did not raise the count");

    pop_data_a: assert property (pop |=> host_data == $past(pop_byte)) // [RQ2]
        else $error("popped byte not presented");

    count_range_a: assert property (cnt_q <= CW'(DEPTH)) // [RQ3]
        else $error("count above depth");

    valid_allow_a: assert property (valid_q && host_pop && !empty && !flush && !push |=> cnt_q == $past(cnt_q) - 1'b1) // [RQ4]
        else $error("valid data not released");

    valid_clear_a: assert property (host_done && !wr_flags |=> !valid_q) // [RQ5]
        else $error("valid not cleared by host read");

    gate_block_a: assert property (valid_gate_en && !valid_q && !push && !flush |=> cnt_q == $past(cnt_q)) // [RQ6]
        else $error("gated read drained fifo");

    flush_empty_a: assert property (flush |=> empty ##1 (cnt_q <= 1)) // [RQ7]
        else $error("flush left entries");

    flush_read_a: assert property (bus.rd && sel_flags |=> !rdata[`UEP4_FLG_FLUSH]) // [RQ7]
        else $error("flush bit read as one");

    ovf_set_a: assert property (wr_data && full |=> ovf_q && cnt_q <= $past(cnt_q)) // [RQ8]
        else $error("overflow not flagged");

    ovf_hold_a: assert property (ovf_q && !(wr_flags && bus.wdata[`UEP4_FLG_OVF]) |=> ovf_q) // [RQ9]
        else $error("overflow dropped without clear");

    full_flag_a: assert property (bus.rd && sel_flags |=> rdata[`UEP4_FLG_FULL] == ($past(cnt_q) == CW'(DEPTH))) // [RQ10]
        else $error("full flag wrong");

    empty_flag_a: assert property (bus.rd && sel_flags |=> rdata[`UEP4_FLG_EMPTY] == ($past(cnt_q) == '0)) // [RQ11]
        else $error("empty flag wrong");

    pkt_write_a: assert property (wr_pkt |=> ep4_max_pkt == $past(bus.wdata[7:0])) // [RQ12]
        else $error("packet size not stored");

    rev_read_a: assert property (bus.rd && sel_rev |=> rdata == {8'h00, REVISION}) // [RQ14]
        else $error("revision read wrong");

    hs_sticky_a: assert property (hs_evt.ep4_stall |=> hs_q[6] [*2] or (hs_q[6] ##1 $past(wr_hs))) // [RQ15]
        else $error("stall flag not held");

    suspend_go_a: assert property (suspend_d |=> suspend_go ##1 !suspend_go) // [RQ16]
        else $error("suspend pulse wrong");

    mbox_valid_a: assert property (hs_evt.ep2_valid |=> hs_q[0]) // [RQ17]
        else $error("mailbox valid not set");

    irq_level_a: assert property (irq == |(ip_q & ie_q))
        else $error("interrupt level mismatch");

    avail_look_a: assert property (host_avail == (!empty && (!$past(valid_gate_en) || valid_q))) // [RQ4]
        else $error("host readiness wrong");

    valid_write_a: assert property (wr_flags |=> valid_q == $past(bus.wdata[`UEP4_FLG_VALID])) // [RQ4]
        else $error("valid bit not written");

    ovf_clear_a: assert property (wr_flags && bus.wdata[`UEP4_FLG_OVF] |=> !ovf_q) // [RQ9]
        else $error("overflow not cleared by one");

    count_read_a: assert property (bus.rd && sel_count |=> rdata == 16'($past(cnt_q))) // [RQ3]
        else $error("count read wrong");

    data_read_a: assert property (bus.rd && sel_data |=> rdata == 16'h0000) // [RQ1]
        else $error("data port read not zero");

    pkt_read_a: assert property (bus.rd && sel_pkt |=> rdata == {8'h00, $past(pkt_q)}) // [RQ12]
        else $error("packet size read wrong");

    hs_clear_a: assert property (wr_hs && bus.wdata[4] && !hs_evt.ep4_ack |=> !hs_q[4]) // [RQ15]
        else $error("ack flag not cleared");

    suspend_clear_a: assert property (wr_hs && bus.wdata[7] && !hs_evt.suspend_req |=> !hs_q[7]) // [RQ16]
        else $error("suspend request not cleared");

    fill_full_c: cover property (push ##1 full);
    overflow_c:  cover property (ovf_evt ##1 irq);
    gated_c:     cover property (valid_gate_en && valid_q ##1 pop ##[1:70] host_done);
    flush_c:     cover property (!empty ##1 flush ##1 empty);
    suspend_c:   cover property (suspend_go);

endmodule
`default_nettype wire

//--- uep4_host_model.sv
// Purpose: behavioural usb host pulling endpoint 4 in data
// Assumes: host_avail is the device's registered readiness flag
// Notes:   slow mode paces pops at random, like a busy host
`timescale 1ns/100ps
`default_nettype none

module uep4_host_model
(
    input  wire logic       clock,      // system clock
    input  wire logic       sys_rst,    // async reset, active high
    input  wire logic [7:0] host_data,  // byte from the device
    input  wire logic       host_avail, // device can give a byte
    output var logic        host_pop,   // take one byte
    output var logic        host_done   // in transfer finished
);
    logic       take_q;
    logic [7:0] got[$];

    initial
    begin
        host_pop  = 1'b0;
        host_done = 1'b0;
    end

    ////////////////////////////////////////
    // a pop only counts when seen together with readiness
    always @(posedge clock or posedge sys_rst)
        if (sys_rst)
            take_q <= 1'b0;
        else
            take_q <= host_pop & host_avail;

    always @(posedge clock)
        if (take_q)
            got.push_back(host_data);

    task automatic in_xfer(input int n, input bit slow);
        int k;
        k = 0;
        while (k < n)
        begin
            @(posedge clock);
            if (host_pop && host_avail)
                k++;
            host_pop <= (k < n) && (!slow || $urandom_range(1, 0));
        end
        @(posedge clock);
        host_done <= 1'b1;
        @(posedge clock);
        host_done <= 1'b0;
    endtask

    // raises pop regardless of readiness, to probe refusal
    task automatic poke(input int c);
        repeat (c)
        begin
            @(posedge clock);
            host_pop <= 1'b1;
        end
        @(posedge clock);
        host_pop <= 1'b0;
    endtask
endmodule

`default_nettype wire

//--- test_usb_ep4_tx_fifo_and_status.sv
// Purpose: self-checking bench of the endpoint 4 transmit slice
// Assumes: host model drives the pop side
// Notes:   random data and sizes from a fixed seed
`timescale 1ns/100ps
`default_nettype none
`include "uep4_defines.svh"

module test_usb_ep4_tx_fifo_and_status;
    import uep4_pkg::*;
    // arbitrary revision value
    localparam logic [7:0] REV = 8'h3C;
    logic        clock;
    logic        sys_rst;
    uep4_bus_s   bus;
    uep4_hs_s    hs_evt;
    logic        valid_gate_en;
    logic [15:0] rdata;
    logic [7:0]  host_data;
    logic [7:0]  ep4_max_pkt;
    logic        host_pop;
    logic        host_done;
    logic        host_avail;
    logic        suspend_go;
    logic        irq;
    int          errors;
    int          n_checks;
    int          n_susp;
    int          i;
    int          n;
    logic [15:0] d;
    logic [7:0]  sent[$];

    uep4_tx #(.DEPTH(64), .REVISION(REV)) dut_u (.clock(clock), .sys_rst(sys_rst), .bus(bus),
        .rdata(rdata), .host_pop(host_pop), .host_done(host_done), .valid_gate_en(valid_gate_en),
        .hs_evt(hs_evt), .host_data(host_data), .host_avail(host_avail), .ep4_max_pkt(ep4_max_pkt),
        .suspend_go(suspend_go), .irq(irq));

    uep4_host_model host_u (.clock(clock), .sys_rst(sys_rst), .host_data(host_data),
        .host_avail(host_avail), .host_pop(host_pop), .host_done(host_done));

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    always @(posedge clock)
        if (suspend_go === 1'b1)
            n_susp++;

    ////////////////////////////////////////
    function automatic logic [15:0] flags_exp(input int cnt, input bit vld, input bit ovf);
        flags_exp = {10'h000, vld, 1'b0, ovf, 1'b0, cnt == 64, cnt == 0};
    endfunction

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        @(posedge clock);
        bus <= {a, v, 2'b10};
        @(posedge clock);
        bus <= '0;
    endtask

    task automatic rdc(input logic [15:0] a, input logic [15:0] exp, input string name);
        @(posedge clock);
        bus <= {a, 16'h0000, 2'b01};
        @(posedge clock);
        bus <= '0;
        @(negedge clock);
        chk(name, rdata, exp);
    endtask

    task automatic push(input int k);
        logic [15:0] v;
        repeat (k)
        begin
            v = 16'($urandom);
            sent.push_back(v[7:0]);
            wr(`UEP4_OFF_DATA, v);
        end
    endtask

    task automatic drain_cmp(input string name);
        repeat (2) @(posedge clock);
        chk(name, 16'(host_u.got.size()), 16'(sent.size()));
        while (sent.size() > 0 && host_u.got.size() > 0)
            chk(name, {8'h00, host_u.got.pop_front()}, {8'h00, sent.pop_front()});
        sent.delete();
    endtask

    task automatic settle;
        repeat (2) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////
    initial
    begin
        void'($urandom(32'h7a8e89c0));
        sys_rst = 1'b1;
        bus = '0;
        hs_evt = '0;
        valid_gate_en = 1'b0;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        rdc(`UEP4_OFF_COUNT, 16'h0000, "count_rst");
        rdc(`UEP4_OFF_FLAGS, 16'h0001, "flags_rst");
        rdc(`UEP4_OFF_PKT, 16'h0008, "pkt_rst");
        chk("max_pkt_rst", {8'h00, ep4_max_pkt}, 16'h0008);
        wr(`UEP4_OFF_REV, 16'hFFFF);
        rdc(`UEP4_OFF_REV, {8'h00, REV}, "rev");
        rdc(`UEP4_OFF_HS, 16'h0000, "hs_rst");
        rdc(`UEP4_OFF_DATA, 16'h0000, "data_rd");
        rdc(16'h4044, 16'h0000, "unmapped");
        d = 16'($urandom);
        wr(`UEP4_OFF_PKT, d);
        rdc(`UEP4_OFF_PKT, {8'h00, d[7:0]}, "pkt_rw");
        chk("max_pkt", {8'h00, ep4_max_pkt}, {8'h00, d[7:0]});
        // plain drain, gate off
        n = $urandom_range(12, 1);
        push(n);
        rdc(`UEP4_OFF_COUNT, 16'(n), "count_n");
        rdc(`UEP4_OFF_FLAGS, flags_exp(n, 0, 0), "flags_n");
        host_u.in_xfer(n, 1'b0);
        drain_cmp("fast");
        rdc(`UEP4_OFF_IRQ_ST, 16'h0006, "irq_st");
        wr(`UEP4_OFF_IRQ_ST, 16'h0007);
        // fill, overflow, flush
        push(64);
        wr(`UEP4_OFF_DATA, 16'h00EE);
        rdc(`UEP4_OFF_COUNT, 16'h0040, "count_full");
        rdc(`UEP4_OFF_FLAGS, flags_exp(64, 0, 1), "flags_ovf");
        wr(`UEP4_OFF_IRQ_EN, 16'h0001);
        settle;
        chk("irq_on", {15'h0000, irq}, 16'h0001);
        wr(`UEP4_OFF_IRQ_EN, 16'h0000);
        settle;
        chk("irq_mask", {15'h0000, irq}, 16'h0000);
        wr(`UEP4_OFF_FLAGS, 16'h0000);
        rdc(`UEP4_OFF_FLAGS, flags_exp(64, 0, 1), "ovf_w0");
        wr(`UEP4_OFF_FLAGS, 16'h0008);
        rdc(`UEP4_OFF_FLAGS, flags_exp(64, 0, 0), "ovf_w1");
        wr(`UEP4_OFF_FLAGS, 16'h0010);
        sent.delete();
        rdc(`UEP4_OFF_COUNT, 16'h0000, "count_flush");
        rdc(`UEP4_OFF_FLAGS, 16'h0001, "flags_flush");
        // gated drain, slow host
        @(posedge clock);
        valid_gate_en <= 1'b1;
        push(3);
        settle;
        chk("avail_gated", {15'h0000, host_avail}, 16'h0000);
        host_u.poke(4);
        rdc(`UEP4_OFF_COUNT, 16'h0003, "count_gated");
        wr(`UEP4_OFF_FLAGS, 16'h0020);
        rdc(`UEP4_OFF_FLAGS, flags_exp(3, 1, 0), "flags_valid");
        chk("avail_valid", {15'h0000, host_avail}, 16'h0001);
        host_u.in_xfer(3, 1'b1);
        drain_cmp("slow");
        rdc(`UEP4_OFF_FLAGS, 16'h0001, "valid_clr");
        // handshake flags, bit 7 also pulses suspend
        for (i = 0; i < 8; i++)
        begin
            @(posedge clock);
            hs_evt <= uep4_hs_s'(8'h01 << i);
            @(posedge clock);
            hs_evt <= '0;
            wr(`UEP4_OFF_HS, 16'h0000);
            rdc(`UEP4_OFF_HS, 16'h0001 << i, "hs_set");
            wr(`UEP4_OFF_HS, 16'h0001 << i);
            rdc(`UEP4_OFF_HS, 16'h0000, "hs_clr");
        end
        chk("suspend_go", 16'(n_susp), 16'h0001);
        tally_and_finish;
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        errors++;
        tally_and_finish;
    end
endmodule

`default_nettype wire
